// [sweep_burst_consts.vh]
// offsets, field positions, reset values and limits for the sweep/burst sequencer
// assumes a 32-bit apb register bus, one aligned word per register
`ifndef SWEEP_BURST_CONSTS_VH
`define SWEEP_BURST_CONSTS_VH

// register byte offsets
`define OFS_CTRL        8'h00
`define OFS_START_FREQ  8'h04
`define OFS_STOP_FREQ   8'h08
`define OFS_MARK_FREQ   8'h0c
`define OFS_BURST_CNT   8'h10
`define OFS_START_PHASE 8'h14
`define OFS_TIMER_PER   8'h18
`define OFS_COMMAND     8'h1c
`define OFS_STATUS      8'h20
`define OFS_CYCLES      8'h24

// control fields
`define CTRL_SWEEP_EN   0
`define CTRL_MARK_EN    1
`define CTRL_BURST_EN   2
`define CTRL_GATED      3
`define CTRL_INFINITE   4
`define CTRL_SRC_LO     5
`define CTRL_SRC_HI     6
`define CTRL_TRIG_OUT   7
`define CTRL_GATE_POL   8
`define CTRL_W          9

// trigger sources
`define SRC_EXT         2'h0
`define SRC_TIMER       2'h1
`define SRC_MANUAL      2'h2
`define SRC_REMOTE      2'h3

// command fields
`define CMD_MANUAL      0
`define CMD_REMOTE      1

// status fields
`define STAT_BURST_RUN  0
`define STAT_SYNC       1
`define STAT_REJECT     2
`define STAT_GATE       3
`define STAT_SWEEP_RUN  4
`define STAT_WAVE_RUN   5

// reset values and limits
`define RST_CTRL        9'h000
`define RST_BURST_CNT   16'h0001
`define RST_TIMER_PER   32'h000f4240
`define BURST_MIN       16'h0001
`define BURST_MAX       16'hc350
`define PHASE_DEG_MAX   9'h168

`endif

// [level_sync.v]
// two-flop synchroniser for asynchronous input levels
// assumes a single clock domain on pclk
`timescale 1ns/1ps
module level_sync #(
   parameter WIDTH = 2
) (
   input  wire             pclk,
   input  wire             presetn,
   input  wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] stage1;
   reg [WIDTH-1:0] stage2;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage1 <= {WIDTH{1'b0}};
         stage2 <= {WIDTH{1'b0}};
      end else begin
         stage1 <= async_in;
         stage2 <= stage1;
      end
   end

   assign sync_out = stage2;
endmodule

// [sweep_burst_sequencer.v]
// sweep sync/marker output and burst sequencing for a waveform synthesizer
// assumes the phase engine advances one record point per point_tick while wave_run is high,
// loads start_index on load_phase, and reports the swept frequency on sweep_freq
`timescale 1ns/1ps
`include "sweep_burst_consts.vh"
module sweep_burst_sequencer #(
   parameter FREQ_W = 32,
   parameter IDX_W  = 13,
   parameter REC_LEN = 8192
) (
   input  wire              pclk,
   input  wire              presetn,
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [7:0]        paddr,
   input  wire [31:0]       pwdata,
   output reg  [31:0]       prdata,
   output wire              pready,
   output wire              pslverr,
   input  wire              trig_in,
   output reg               trig_out,
   output wire              trig_oe,
   output reg               sync_out,
   output reg               sweep_start,
   input  wire              sweep_done,
   input  wire [FREQ_W-1:0] sweep_freq,
   output reg  [FREQ_W-1:0] start_freq,
   output reg  [FREQ_W-1:0] stop_freq,
   output reg               wave_run,
   output reg               load_phase,
   output reg  [IDX_W-1:0]  start_index,
   input  wire              point_tick,
   input  wire [IDX_W-1:0]  phase_index
);
   localparam ST_IDLE = 1'b0;
   localparam ST_RUN  = 1'b1;

   reg [`CTRL_W-1:0] ctrl;
   reg [FREQ_W-1:0]  mark_freq;
   reg [15:0]        burst_cnt;
   reg [8:0]         phase_deg;
   reg [31:0]        timer_per;
   reg [31:0]        timer_cnt;
   reg               reject;
   reg               state;
   reg [15:0]        cycles_done;
   reg               sweep_active;
   reg               sweep_up;
   reg               trig_q;
   reg               gate_stop;

   wire       pin_sync;
   wire       trig_lvl = pin_sync;
   wire [1:0] trig_src = ctrl[`CTRL_SRC_HI:`CTRL_SRC_LO];

   level_sync #(
      .WIDTH    (1)
   ) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (trig_in),
      .sync_out (pin_sync)
   );

   // apb decode
   function mapped;
      input [7:0] a;
      begin
         if (a == `OFS_CTRL || a == `OFS_START_FREQ || a == `OFS_STOP_FREQ)
            mapped = 1'b1;
         else if (a == `OFS_MARK_FREQ || a == `OFS_BURST_CNT || a == `OFS_START_PHASE)
            mapped = 1'b1;
         else if (a == `OFS_TIMER_PER || a == `OFS_COMMAND || a == `OFS_STATUS)
            mapped = 1'b1;
         else if (a == `OFS_CYCLES)
            mapped = 1'b1;
         else
            mapped = 1'b0;
      end
   endfunction

   // degrees to record point: 0 -> first, 360 -> last
   function [IDX_W-1:0] deg_to_index;
      input [8:0] deg;
      reg   [31:0] prod;
      begin
         prod = deg * (REC_LEN - 1);
         prod = prod / 360;
         deg_to_index = prod[IDX_W-1:0];
      end
   endfunction

   wire wr_en  = psel & penable & pwrite;
   wire setup  = psel & ~penable;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped(paddr);

   wire cmd_wr  = wr_en && paddr == `OFS_COMMAND;
   wire manual  = cmd_wr & pwdata[`CMD_MANUAL];
   wire remote  = cmd_wr & pwdata[`CMD_REMOTE];

   wire [FREQ_W-1:0] span_lo = (start_freq <= stop_freq) ? start_freq : stop_freq;
   wire [FREQ_W-1:0] span_hi = (start_freq <= stop_freq) ? stop_freq : start_freq;
   wire mark_ok = pwdata[FREQ_W-1:0] >= span_lo && pwdata[FREQ_W-1:0] <= span_hi;
   // upper bits must be clear so an oversized word cannot alias into range
   wire cnt_ok  = pwdata[31:16] == 16'h0000 && pwdata[15:0] >= `BURST_MIN &&
                  pwdata[15:0] <= `BURST_MAX;
   wire phase_ok = pwdata[31:9] == 23'h000000 && pwdata[8:0] <= `PHASE_DEG_MAX;

   // register writes
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl       <= `RST_CTRL;
         start_freq <= {FREQ_W{1'b0}};
         stop_freq  <= {FREQ_W{1'b0}};
         mark_freq  <= {FREQ_W{1'b0}};
         burst_cnt  <= `RST_BURST_CNT;
         phase_deg  <= 9'h000;
         timer_per  <= `RST_TIMER_PER;
         reject     <= 1'b0;
      end else if (wr_en) begin
         if (paddr == `OFS_CTRL) begin
            ctrl <= pwdata[`CTRL_W-1:0];
         end else if (paddr == `OFS_START_FREQ) begin
            start_freq <= pwdata[FREQ_W-1:0];
         end else if (paddr == `OFS_STOP_FREQ) begin
            stop_freq <= pwdata[FREQ_W-1:0];
         end else if (paddr == `OFS_MARK_FREQ) begin
            if (mark_ok)
               mark_freq <= pwdata[FREQ_W-1:0];
            reject <= ~mark_ok;
         end else if (paddr == `OFS_BURST_CNT) begin
            if (cnt_ok)
               burst_cnt <= pwdata[15:0];
            reject <= ~cnt_ok;
         end else if (paddr == `OFS_START_PHASE) begin
            if (phase_ok)
               phase_deg <= pwdata[8:0];
            reject <= ~phase_ok;
         end else if (paddr == `OFS_TIMER_PER) begin
            timer_per <= pwdata;
         end
      end
   end

   // read data captured in setup, stands through access
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (setup) begin
         prdata <= 32'h00000000;
         if (paddr == `OFS_CTRL)
            prdata[`CTRL_W-1:0] <= ctrl;
         else if (paddr == `OFS_START_FREQ)
            prdata[FREQ_W-1:0] <= start_freq;
         else if (paddr == `OFS_STOP_FREQ)
            prdata[FREQ_W-1:0] <= stop_freq;
         else if (paddr == `OFS_MARK_FREQ)
            prdata[FREQ_W-1:0] <= mark_freq;
         else if (paddr == `OFS_BURST_CNT)
            prdata[15:0] <= burst_cnt;
         else if (paddr == `OFS_START_PHASE)
            prdata[8:0] <= phase_deg;
         else if (paddr == `OFS_TIMER_PER)
            prdata <= timer_per;
         else if (paddr == `OFS_STATUS)
            prdata[5:0] <= {wave_run, sweep_active, trig_lvl ^ ctrl[`CTRL_GATE_POL],
                            reject, sync_out, state};
         else if (paddr == `OFS_CYCLES)
            prdata[15:0] <= cycles_done;
      end
   end

   // internal timer trigger
   wire timer_hit = trig_src == `SRC_TIMER && timer_cnt >= timer_per;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         timer_cnt <= 32'h00000000;
      else if (trig_src != `SRC_TIMER || timer_hit)
         timer_cnt <= 32'h00000000;
      else
         timer_cnt <= timer_cnt + 32'h00000001;
   end

   // trigger selection
   wire ext_used = ~ctrl[`CTRL_TRIG_OUT];
   wire ext_edge = ext_used & trig_lvl & ~trig_q;
   reg  trig;
   always @* begin
      trig = 1'b0;
      case (trig_src)
         `SRC_EXT:    trig = ext_edge;
         `SRC_TIMER:  trig = timer_hit;
         `SRC_MANUAL: trig = manual;
         `SRC_REMOTE: trig = remote;
         default:     trig = 1'b0;
      endcase
   end
   wire internal_trig = trig & (trig_src != `SRC_EXT);

   assign trig_oe = ctrl[`CTRL_TRIG_OUT];
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_q   <= 1'b0;
         trig_out <= 1'b0;
      end else begin
         trig_q   <= trig_lvl;
         trig_out <= ctrl[`CTRL_TRIG_OUT] & internal_trig;
      end
   end

   // sweep and sync
   wire burst_mode = ctrl[`CTRL_BURST_EN];
   wire sweep_mode = ctrl[`CTRL_SWEEP_EN] & ~burst_mode;
   wire [FREQ_W:0] mid_sum = {1'b0, start_freq} + {1'b0, stop_freq};
   wire [FREQ_W-1:0] mid_freq = mid_sum[FREQ_W:1];
   wire [FREQ_W-1:0] fall_freq = ctrl[`CTRL_MARK_EN] ? mark_freq : mid_freq;
   wire reached = sweep_up ? (sweep_freq >= fall_freq) : (sweep_freq <= fall_freq);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sweep_active <= 1'b0;
         sweep_start  <= 1'b0;
         sweep_up     <= 1'b1;
         sync_out     <= 1'b0;
      end else begin
         sweep_start <= 1'b0;
         if (!sweep_mode) begin
            sweep_active <= 1'b0;
            sync_out     <= 1'b0;
         end else if (!sweep_active && trig) begin
            sweep_start  <= 1'b1;
            sweep_active <= 1'b1;
            sweep_up     <= start_freq <= stop_freq;
            sync_out     <= 1'b1;
         end else if (sweep_active) begin
            if (sweep_done)
               sweep_active <= 1'b0;
            if (!sweep_start && reached)
               sync_out <= 1'b0;
         end
      end
   end

   // burst sequencing
   wire gate_true = (trig_lvl ^ ctrl[`CTRL_GATE_POL]) & ext_used;
   wire gated     = ctrl[`CTRL_GATED];
   wire cycle_end = point_tick & (phase_index == start_index);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state       <= ST_IDLE;
         wave_run    <= 1'b0;
         load_phase  <= 1'b0;
         start_index <= {IDX_W{1'b0}};
         cycles_done <= 16'h0000;
         gate_stop   <= 1'b0;
      end else begin
         load_phase <= 1'b0;
         if (state == ST_IDLE)
            start_index <= deg_to_index(phase_deg);
         case (state)
            ST_IDLE: begin
               wave_run  <= 1'b0;
               gate_stop <= 1'b0;
               if (burst_mode && gated && gate_true) begin
                  state      <= ST_RUN;
                  wave_run   <= 1'b1;
                  load_phase <= 1'b1;
               end else if (burst_mode && !gated && trig) begin
                  state       <= ST_RUN;
                  wave_run    <= 1'b1;
                  load_phase  <= 1'b1;
                  cycles_done <= 16'h0000;
               end
            end
            ST_RUN: begin
               // further triggers have no effect here
               if (!burst_mode) begin
                  state    <= ST_IDLE;
                  wave_run <= 1'b0;
               end else if (gated) begin
                  if (!gate_true)
                     gate_stop <= 1'b1;
                  if (cycle_end && (gate_stop || !gate_true)) begin
                     state    <= ST_IDLE;
                     wave_run <= 1'b0;
                  end
               end else if (cycle_end) begin
                  if (!ctrl[`CTRL_INFINITE]) begin
                     cycles_done <= cycles_done + 16'h0001;
                     if (cycles_done + 16'h0001 >= burst_cnt) begin
                        state    <= ST_IDLE;
                        wave_run <= 1'b0;
                     end
                  end
               end
            end
            default: begin
               state    <= ST_IDLE;
               wave_run <= 1'b0;
            end
         endcase
      end
   end
endmodule

// [sweep_burst_props.sv]
// assertions on the sweep/burst sequencer ports
// assumes binding onto every sweep_burst_sequencer instance
`timescale 1ns/1ps
module sweep_burst_props #(
   parameter IDX_W = 13
) (
   input wire             pclk,
   input wire             presetn,
   input wire             psel,
   input wire             penable,
   input wire [7:0]       paddr,
   input wire             pslverr,
   input wire             trig_out,
   input wire             trig_oe,
   input wire             sync_out,
   input wire             sweep_start,
   input wire             wave_run,
   input wire             load_phase,
   input wire             point_tick,
   input wire [IDX_W-1:0] phase_index,
   input wire [IDX_W-1:0] start_index
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence access_s;
      psel && penable;
   endsequence
   sequence away_s;
      wave_run && !(point_tick && phase_index == start_index);
   endsequence
   unmapped_err_a: assert property (access_s ##0 (paddr > 8'h27) |-> pslverr)
      else $error("unmapped access without slave error");
   stray_err_a: assert property (pslverr |-> access_s)
      else $error("slave error outside an access");
   sync_rise_a: assert property (sweep_start |-> sync_out)
      else $error("sync low at sweep start");
   sweep_once_a: assert property (sweep_start |=> !sweep_start [*8])
      else $error("second sweep start too soon");
   home_stop_a: assert property (away_s |=> wave_run)
      else $error("waveform stopped away from start phase");
   load_run_a: assert property (load_phase |-> wave_run ##1 !load_phase)
      else $error("phase load without run or too long");
   fresh_start_a: assert property (load_phase |-> !$past(wave_run))
      else $error("burst restarted while running");
   trig_dir_a: assert property (trig_out |-> trig_oe ##1 !trig_out)
      else $error("trigger output pulse wrong");
endmodule

bind sweep_burst_sequencer sweep_burst_props #(.IDX_W(IDX_W)) props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
   .pslverr(pslverr), .trig_out(trig_out), .trig_oe(trig_oe), .sync_out(sync_out),
   .sweep_start(sweep_start), .wave_run(wave_run), .load_phase(load_phase),
   .point_tick(point_tick), .phase_index(phase_index), .start_index(start_index)
);

// [phase_engine_model.sv]
// behavioural phase/sweep engine facing the sequencer
// assumes one record point per cycle and a unit frequency step
`timescale 1ns/1ps
module phase_engine_model (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        sweep_start,
   input  wire [31:0] start_freq,
   input  wire [31:0] stop_freq,
   input  wire        wave_run,
   input  wire        load_phase,
   input  wire [12:0] start_index,
   output reg         sweep_done,
   output reg  [31:0] sweep_freq,
   output reg         point_tick,
   output reg  [12:0] phase_index
);
   reg sweeping;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sweeping <= 1'b0;
         sweep_done <= 1'b0;
         sweep_freq <= 32'h0;
         point_tick <= 1'b0;
         phase_index <= 13'h0;
      end else begin
         sweep_done <= 1'b0;
         point_tick <= 1'b0;
         if (sweep_start) begin
            sweeping <= 1'b1;
            sweep_freq <= start_freq;
         end else if (sweeping && sweep_freq >= stop_freq) begin
            sweeping <= 1'b0;
            sweep_done <= 1'b1;
         end else if (sweeping) begin
            sweep_freq <= sweep_freq + 32'h1;
         end
         if (load_phase) begin
            phase_index <= start_index;
         end else if (wave_run) begin
            point_tick <= 1'b1;
            phase_index <= phase_index + 13'h1;
         end
      end
   end
endmodule

// [test_sweep_burst_sequencer.sv]
// self-checking bench for the sweep/burst sequencer
// assumes phase_engine_model as the engine and the bench as trigger source
`timescale 1ns/1ps
`include "sweep_burst_consts.vh"
module test_sweep_burst_sequencer;
   logic        pclk, presetn, psel, penable, pwrite, trig_drv, perr, last_sync;
   logic [7:0]  paddr;
   logic [31:0] pwdata, rdat, seed;
   wire         pready, pslverr, trig_out, trig_oe, sync_out, sweep_start, sweep_done;
   wire         wave_run, load_phase, point_tick;
   wire  [31:0] prdata, sweep_freq, start_freq, stop_freq;
   wire  [12:0] start_index, phase_index;
   wire         trig_in = trig_oe ? trig_out : trig_drv;
   int          err_count, num_checks, n_start, n_done, n_match, n_trig, fall_freq;
   int          exp_idx, i, d, m0, t0;
   logic [7:0]  ra[8] = '{`OFS_MARK_FREQ, `OFS_MARK_FREQ, `OFS_MARK_FREQ, `OFS_BURST_CNT,
                          `OFS_BURST_CNT, `OFS_BURST_CNT, `OFS_START_PHASE, `OFS_START_PHASE};
   int          rv[8] = '{201, 99, 200, 0, 50001, 50000, 361, 360};
   logic        rr[8] = '{1, 1, 0, 1, 1, 0, 1, 0};

   sweep_burst_sequencer DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .trig_in(trig_in), .trig_out(trig_out), .trig_oe(trig_oe), .sync_out(sync_out),
      .sweep_start(sweep_start), .sweep_done(sweep_done), .sweep_freq(sweep_freq),
      .start_freq(start_freq), .stop_freq(stop_freq), .wave_run(wave_run),
      .load_phase(load_phase), .start_index(start_index), .point_tick(point_tick),
      .phase_index(phase_index));
   phase_engine_model engine (
      .pclk(pclk), .presetn(presetn), .sweep_start(sweep_start), .start_freq(start_freq),
      .stop_freq(stop_freq), .wave_run(wave_run), .load_phase(load_phase),
      .start_index(start_index), .sweep_done(sweep_done), .sweep_freq(sweep_freq),
      .point_tick(point_tick), .phase_index(phase_index));

   initial begin
      pclk = 0;
      forever #5 pclk = ~pclk;
   end
   // reference counters of engine and trigger output events
   always @(posedge pclk) begin
      n_start <= n_start + sweep_start;
      n_done <= n_done + sweep_done;
      n_trig <= n_trig + trig_out;
      n_match <= n_match + (wave_run && point_tick && phase_index == exp_idx[12:0]);
      last_sync <= sync_out;
      if (last_sync && !sync_out) fall_freq <= sweep_freq;
   end

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= dt;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdat = prdata;
      perr = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task automatic pulse();
      trig_drv <= 1;
      repeat (4) @(posedge pclk);
      trig_drv <= 0;
      repeat (4) @(posedge pclk);
   endtask
   task automatic wait_run(input logic lvl, input int lim);
      for (int k = 0; k < lim && wave_run !== lvl; k++) @(posedge pclk);
      chk("wave_run", lvl, wave_run);
   endtask
   task stop_test();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial begin
      repeat (90000) @(posedge pclk);
      err_count++;
      stop_test();
   end

   initial begin
      {presetn, psel, penable, pwrite, trig_drv} = 0;
      paddr = 0;
      pwdata = 0;
      seed = 32'h714e5b34;
      exp_idx = 90 * 8191 / 360;
      repeat (20) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      apb(0, `OFS_BURST_CNT, 0);
      chk("burst_cnt", 1, rdat);
      apb(0, `OFS_TIMER_PER, 0);
      chk("timer_per", 32'h000f4240, rdat);
      apb(0, 8'h40, 0);
      chk("pslverr", 1, perr);
      apb(1, `OFS_START_FREQ, 100);
      apb(1, `OFS_STOP_FREQ, 200);
      chk("start_freq", 100, start_freq);
      chk("stop_freq", 200, stop_freq);
      for (i = 0; i < 8; i++) begin
         apb(1, ra[i], rv[i]);
         apb(0, `OFS_STATUS, 0);
         chk("reject", rr[i], rdat[`STAT_REJECT]);
      end
      chk("start_index", 8191, start_index);
      apb(0, `OFS_BURST_CNT, 0);
      chk("burst_cnt", 50000, rdat);
      d = 101 + xs() % 98;
      apb(1, `OFS_MARK_FREQ, d);
      for (i = 0; i < 3; i++) begin
         apb(1, `OFS_CTRL, i == 2 ? 32'h01 : (i == 1 ? 32'h43 : 32'h41));
         if (i == 2) pulse();
         else apb(1, `OFS_COMMAND, 1);
         if (i == 2) repeat (20) @(posedge pclk);
         if (i == 2) pulse();
         for (int k = 0; k < 400 && n_done < i + 1; k++) @(posedge pclk);
         chk("sweeps", i + 1, n_start);
         chk("sync_fall", (i == 1 ? d : 150) + 1, fall_freq);
      end
      apb(1, `OFS_START_PHASE, 90);
      apb(1, `OFS_TIMER_PER, 10);
      chk("start_index", exp_idx, start_index);
      for (i = 0; i < 4; i++) begin
         apb(1, `OFS_BURST_CNT, i == 0 ? 2 : 1);
         apb(1, `OFS_CTRL, 32'h04 | (i << 5) | (i ? 32'h80 : 0));
         m0 = n_match;
         t0 = n_trig;
         if (i != 1) repeat (20) @(posedge pclk);
         if (i != 1) chk("idle", 0, wave_run);
         if (i == 0) pulse();
         if (i >= 2) apb(1, `OFS_COMMAND, i - 1);
         wait_run(1, 40);
         if (i == 1) apb(1, `OFS_TIMER_PER, 32'hffffffff);
         if (i == 0) pulse();
         wait_run(0, 20000);
         chk("cycles", i == 0 ? 2 : 1, n_match - m0);
         apb(0, `OFS_CYCLES, 0);
         chk("cycles_reg", i == 0 ? 2 : 1, rdat);
         chk("trig_out", i ? 1 : 0, n_trig - t0);
      end
      apb(1, `OFS_CTRL, 32'h0c);
      m0 = n_match;
      trig_drv <= 1;
      wait_run(1, 20);
      repeat (3000) @(posedge pclk);
      chk("gate_run", 1, wave_run);
      trig_drv <= 0;
      wait_run(0, 8300);
      chk("gate_cycles", 1, n_match - m0);
      apb(1, `OFS_CTRL, 32'h54);
      m0 = n_match;
      apb(1, `OFS_COMMAND, 1);
      repeat (16500) @(posedge pclk);
      chk("inf_run", 1, wave_run);
      chk("inf_cycles", 2, n_match - m0);
      presetn <= 0;
      repeat (3) @(posedge pclk);
      chk("reset_run", 0, wave_run);
      presetn <= 1;
      stop_test();
   end
endmodule
